// File: sim/autoreload_pwm_capture_timer_test.sv
// Self-checking bench for the auto-reload PWM capture timer
`timescale 1ns/10ps
`default_nettype none
`include "art_pwm_defs.svh"
module autoreload_pwm_capture_timer_test;
  import art_pwm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, ext_clock, overflow_irq;
  logic [1:0]  capture_input, capture_irq;
  logic [3:0]  waveform_out, waveform_oe;
  int          failures, n_tests;
  byte_t       q;
  autoreload_pwm_capture_timer autoreload_pwm_capture_timer_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_clock, .capture_input, .waveform_out, .waveform_oe,
    .overflow_irq, .capture_irq);
  pin_driver pin_driver_i (.pclk, .capture_input, .ext_clock);
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task conclude;
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One APB transfer; read data lands in q
  task apb(input logic wr, input logic [7:0] a, input byte_t d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata[7:0];
    check(prdata[31:8], 32'h0);
    check(pslverr, 1'h0);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task settle;
    repeat (2) @(negedge pclk);
  endtask
  task t_reset;
    apb(0, `OFF_TIMER_CS, 8'h00);
    check(q, 8'h00);
    apb(1, `OFF_CAPTURE_CS, 8'hC0);
    apb(0, `OFF_CAPTURE_CS, 8'h00);
    check(q, 8'h00);
    apb(0, 8'h3C, 8'h00);
    check(q, 8'h00);
  endtask
  task t_force;
    apb(1, `OFF_RELOAD, 8'hA5);
    apb(1, `OFF_TIMER_CS, 8'h05);
    apb(0, `OFF_COUNTER, 8'h00);
    check(q, 8'hA5);
    apb(0, `OFF_TIMER_CS, 8'h00);
    check(q, 8'h00);
    repeat (5) @(posedge pclk);
    apb(0, `OFF_COUNTER, 8'h00);
    check(q, 8'hA5);
  endtask
  task t_overflow;
    apb(1, `OFF_RELOAD, 8'h10);
    apb(1, `OFF_COUNTER, 8'hFD);
    apb(1, `OFF_TIMER_CS, 8'h0A);
    repeat (12) @(posedge pclk);
    apb(1, `OFF_TIMER_CS, 8'h02);
    settle;
    check(overflow_irq, 1'h1);
    apb(0, `OFF_TIMER_CS, 8'h00);
    check(q, 8'h03);
    settle;
    check(overflow_irq, 1'h0);
    apb(0, `OFF_TIMER_CS, 8'h00);
    check(q, 8'h02);
    apb(0, `OFF_COUNTER, 8'h00);
    check(q >= 8'h10 && q < 8'h20, 1'h1);
  endtask
  task t_prescale;
    apb(1, `OFF_TIMER_CS, 8'h78);
    apb(1, `OFF_COUNTER, 8'h00);
    repeat (300) @(posedge pclk);
    apb(0, `OFF_COUNTER, 8'h00);
    check(q, 8'h02);
    apb(1, `OFF_TIMER_CS, 8'h00);
  endtask
  task t_external;
    apb(1, `OFF_TIMER_CS, 8'h88);
    apb(1, `OFF_COUNTER, 8'h20);
    repeat (20) @(posedge pclk);
    pin_driver_i.pulse_ext(5);
    repeat (4) @(posedge pclk);
    apb(0, `OFF_COUNTER, 8'h00);
    check(q, 8'h25);
    apb(1, `OFF_TIMER_CS, 8'h00);
  endtask
  task duty_all(input byte_t d);
    apb(1, `OFF_DUTY0, d);
    apb(1, `OFF_DUTY1, d);
    apb(1, `OFF_DUTY2, d);
    apb(1, `OFF_DUTY3, d);
  endtask
  // Run across one overflow, then park the counter at 40h
  task wrap_and_park;
    apb(1, `OFF_COUNTER, 8'hFE);
    apb(1, `OFF_TIMER_CS, 8'h08);
    repeat (4) @(posedge pclk);
    apb(1, `OFF_TIMER_CS, 8'h00);
    apb(1, `OFF_COUNTER, 8'h40);
    settle;
  endtask
  task t_pwm;
    apb(1, `OFF_RELOAD, 8'h00);
    duty_all(8'h80);
    apb(1, `OFF_PWM_CTRL, 8'hF0);
    wrap_and_park;
    check(waveform_out, 4'hF);
    check(waveform_oe, 4'hF);
    apb(1, `OFF_PWM_CTRL, 8'hF5);
    settle;
    check(waveform_out, 4'hA);
    apb(1, `OFF_PWM_CTRL, 8'h30);
    duty_all(8'h02);
    settle;
    check(waveform_out, 4'h3);
    check(waveform_oe, 4'h3);
    wrap_and_park;
    check(waveform_out, 4'h0);
  endtask
  task t_capture;
    apb(1, `OFF_COUNTER, 8'h33);
    apb(1, `OFF_CAPTURE_CS, 8'hDC);
    pin_driver_i.set_capture(0, 1'h1);
    repeat (4) @(posedge pclk);
    settle;
    check(capture_irq, 2'h1);
    apb(0, `OFF_CAPTURE_CS, 8'h00);
    check(q, 8'h1D);
    apb(1, `OFF_COUNTER, 8'h44);
    pin_driver_i.set_capture(0, 1'h0);
    pin_driver_i.set_capture(0, 1'h1);
    repeat (4) @(posedge pclk);
    apb(0, `OFF_CAPTURE1, 8'h00);
    check(q, 8'h33);
    settle;
    check(capture_irq, 2'h0);
    pin_driver_i.set_capture(1, 1'h1);
    repeat (4) @(posedge pclk);
    apb(0, `OFF_CAPTURE_CS, 8'h00);
    check(q, 8'h1C);
    pin_driver_i.set_capture(1, 1'h0);
    repeat (4) @(posedge pclk);
    settle;
    check(capture_irq, 2'h2);
    apb(0, `OFF_CAPTURE2, 8'h00);
    check(q, 8'h44);
  endtask
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    failures = 0;
    n_tests = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    t_reset;
    t_force;
    t_overflow;
    t_prescale;
    t_external;
    t_pwm;
    t_capture;
    conclude;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    conclude;
  end
endmodule
`default_nettype wire

// File: sim/pin_driver.sv
// Capture signal source and external clock source for the timer pins
`timescale 1ns/10ps
`default_nettype none
module pin_driver (
  input  wire logic       pclk,
  output logic      [1:0] capture_input,
  output logic            ext_clock
);
  initial begin
    capture_input = 2'h0;
    ext_clock     = 1'h0;
  end
  // Level change on one capture pin, launched after a clock edge
  task set_capture(input int ch, input logic lvl);
    @(posedge pclk);
    capture_input[ch] <= lvl;
  endtask
  // Burst of slow pulses; the clock idles low between bursts
  task pulse_ext(input int n);
    repeat (n) begin
      @(posedge pclk);
      ext_clock <= 1'h1;
      repeat (2) @(posedge pclk);
      ext_clock <= 1'h0;
      @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

// File: verilog/art_pwm_defs.svh
// Register offsets, field positions and reset values of the auto-reload PWM timer
`ifndef ART_PWM_DEFS_SVH
`define ART_PWM_DEFS_SVH
`define OFF_DUTY3       8'h00
`define OFF_DUTY2       8'h04
`define OFF_DUTY1       8'h08
`define OFF_DUTY0       8'h0C
`define OFF_PWM_CTRL    8'h10
`define OFF_TIMER_CS    8'h14
`define OFF_COUNTER     8'h18
`define OFF_RELOAD      8'h1C
`define OFF_CAPTURE_CS  8'h20
`define OFF_CAPTURE1    8'h24
`define OFF_CAPTURE2    8'h28
`define BIT_EXT_CLK     7
`define BIT_RUN         3
`define BIT_FORCE       2
`define BIT_OVF_IE      1
`define BIT_OVF         0
`define RESET_BYTE      8'h00
`define COUNTER_TOP     8'hFF
`endif

// File: verilog/art_pwm_pkg.sv
// Types shared by the auto-reload PWM timer
package art_pwm_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] prescale_t;
endpackage

// File: verilog/autoreload_pwm_capture_timer.sv
// APB auto-reload PWM timer with two input-capture channels
// Notes on behaviour
// [RULE1] Control bit 7 picks prescaler input: CPU clock or external clock.
// [RULE2] Bits 6:4 divide prescaler input by two to the field value.
// [RULE3] Bit 3 runs the counter; cleared freezes prescaler and counter.
// [RULE4] Force-reload bit is write-only and reads zero.
// [RULE5] Writing force-reload loads reload value and clears prescaler.
// [RULE6] Overflow request only while overflow flag and enable both set.
// [RULE7] Overflow flag set by hardware, cleared by control read, not set by writes.
// [RULE8] Overflow is counter passing FFh and reloading.
// [RULE9] Counter register reads live count, writes replace it even while running.
// [RULE10] On overflow counter loads the reload value.
// [RULE11] On overflow each output goes to its start-of-period level.
// [RULE12] PWM control bits 7:4 enable each output pin.
// [RULE13] Bits 3:0 polarity: 0 means high while count not above compare.
// [RULE14] A polarity change inverts the output at once.
// [RULE15] Duty register sets second edge; first edge is at reload.
// [RULE16] Capture control bits 7:6 read zero.
// [RULE17] Bits 5:4 select capture edge: 1 rising, 0 falling.
// [RULE18] Capture request only while enable and flag both set.
// [RULE19] Capture flag set on capture, cleared by reading its capture value.
// [RULE20] Control register reads zero after reset.
// [RULE21] Compare shadows load from duty registers at each overflow.
// [RULE22] Selected edge copies counter into capture value register.
// [RULE23] After a capture, further captures blocked until value is read.
// [RULE24] Writing counter register also clears the prescaler.
// [RULE25] Clear-on-read effects act only on completed reads.
`timescale 1ns/10ps
`default_nettype none
`include "art_pwm_defs.svh"
module autoreload_pwm_capture_timer #(
  parameter int CHANNELS = 4
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               ext_clock,
  input  wire logic [1:0]         capture_input,
  output logic      [CHANNELS-1:0] waveform_out,
  output logic      [CHANNELS-1:0] waveform_oe,
  output logic                    overflow_irq,
  output logic      [1:0]         capture_irq
);
  import art_pwm_pkg::*;

  // Channel logic is written for exactly four outputs
  if (CHANNELS != 4) begin : g_bad_channels
    $error("CHANNELS must be 4");
  end

  logic                 external_clock_select;
  prescale_t            prescale_select;
  logic                 counter_run;
  logic                 overflow_irq_enable;
  logic                 overflow_flag;
  byte_t                counter;
  byte_t                reload_value;
  logic [3:0]           output_enable;
  logic [3:0]           polarity_bits;
  byte_t                duty_cycle [4];
  byte_t                compare_shadow [4];
  logic [1:0]           capture_edge;
  logic [1:0]           capture_irq_enable;
  logic [1:0]           capture_flag;
  byte_t                capture_value [2];
  logic [6:0]           prescaler;
  logic                 ext_prev;
  logic [1:0]           cap_prev;
  logic                 wr;
  logic                 rd;
  logic                 input_tick;
  logic                 count_tick;
  logic                 overflow;
  logic [1:0]           cap_event;
  logic [6:0]           next_prescaler;
  logic [7:0]           rbyte;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  // Single-cycle access phase; effects only at completion
  assign wr = psel && penable && pwrite; // [RULE25]
  assign rd = psel && penable && !pwrite; // [RULE25]

  // External clock rising edges feed the prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev <= 1'b0;
      cap_prev <= 2'b00;
    end else begin
      ext_prev <= ext_clock;
      cap_prev <= capture_input;
    end
  end

  assign input_tick = external_clock_select ? (ext_clock && !ext_prev) : 1'b1; // [RULE1]
  assign next_prescaler = prescaler + 7'h01;
  always_comb begin
    if (prescale_select == 3'h0) begin
      count_tick = input_tick;
    end else begin
      // Tap fires when the low bits roll over
      count_tick = input_tick && ((prescaler & ((7'h01 << prescale_select) - 7'h01))
                                  == ((7'h01 << prescale_select) - 7'h01)); // [RULE2]
    end
    count_tick = count_tick && counter_run; // [RULE3]
  end
  assign overflow = count_tick && (counter == `COUNTER_TOP); // [RULE8]

  // Prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescaler <= 7'h00;
    end else if ((wr && paddr == `OFF_TIMER_CS && pwdata[`BIT_FORCE]) ||
                 (wr && paddr == `OFF_COUNTER)) begin
      prescaler <= 7'h00; // [RULE5] [RULE24]
    end else if (counter_run && input_tick) begin
      prescaler <= next_prescaler; // [RULE3]
    end
  end

  // Counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter <= 8'h00;
    end else if (wr && paddr == `OFF_COUNTER) begin
      counter <= pwdata[7:0]; // [RULE9]
    end else if (wr && paddr == `OFF_TIMER_CS && pwdata[`BIT_FORCE]) begin
      counter <= reload_value; // [RULE5]
    end else if (overflow) begin
      counter <= reload_value; // [RULE10]
    end else if (count_tick) begin
      counter <= counter + 8'h01;
    end
  end

  // Timer control and status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_clock_select <= 1'b0; // [RULE20]
      prescale_select       <= 3'h0;
      counter_run           <= 1'b0;
      overflow_irq_enable   <= 1'b0;
    end else if (wr && paddr == `OFF_TIMER_CS) begin
      external_clock_select <= pwdata[`BIT_EXT_CLK];
      prescale_select       <= pwdata[6:4];
      counter_run           <= pwdata[`BIT_RUN];
      overflow_irq_enable   <= pwdata[`BIT_OVF_IE];
    end
  end

  // Overflow flag: set beats a clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
    end else if (overflow) begin
      overflow_flag <= 1'b1; // [RULE7]
    end else if (rd && paddr == `OFF_TIMER_CS) begin
      overflow_flag <= 1'b0; // [RULE7]
    end
  end
  assign overflow_irq = overflow_flag && overflow_irq_enable; // [RULE6]

  // PWM control, duty and compare shadows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_value  <= 8'h00;
      output_enable <= 4'h0;
      polarity_bits <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        duty_cycle[i]     <= 8'h00;
        compare_shadow[i] <= 8'h00;
      end
    end else begin
      if (wr && paddr == `OFF_RELOAD) begin
        reload_value <= pwdata[7:0];
      end
      if (wr && paddr == `OFF_PWM_CTRL) begin
        output_enable <= pwdata[7:4];
        polarity_bits <= pwdata[3:0];
      end
      if (wr && paddr == `OFF_DUTY0) begin
        duty_cycle[0] <= pwdata[7:0];
      end
      if (wr && paddr == `OFF_DUTY1) begin
        duty_cycle[1] <= pwdata[7:0];
      end
      if (wr && paddr == `OFF_DUTY2) begin
        duty_cycle[2] <= pwdata[7:0];
      end
      if (wr && paddr == `OFF_DUTY3) begin
        duty_cycle[3] <= pwdata[7:0];
      end
      if (overflow) begin
        for (int i = 0; i < 4; i++) begin
          compare_shadow[i] <= duty_cycle[i]; // [RULE21]
        end
      end
    end
  end

  // Level follows counter against shadow; polarity applies at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waveform_out <= '0;
      waveform_oe  <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        // Start-of-period level right after reload, edge when count passes shadow
        waveform_out[i] <= output_enable[i] &&
                           (((counter <= compare_shadow[i]) ? 1'b1 : 1'b0) ^ polarity_bits[i]); // [RULE11] [RULE13] [RULE14] [RULE15]
        waveform_oe[i]  <= output_enable[i]; // [RULE12]
      end
    end
  end

  // Capture
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      cap_event[c] = capture_edge[c] ? (capture_input[c] && !cap_prev[c])
                                     : (!capture_input[c] && cap_prev[c]); // [RULE17]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_edge       <= 2'b00;
      capture_irq_enable <= 2'b00;
    end else if (wr && paddr == `OFF_CAPTURE_CS) begin
      capture_edge       <= pwdata[5:4];
      capture_irq_enable <= pwdata[3:2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_flag     <= 2'b00;
      capture_value[0] <= 8'h00;
      capture_value[1] <= 8'h00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (cap_event[c] && !capture_flag[c]) begin
          capture_value[c] <= counter; // [RULE22] [RULE23]
          capture_flag[c]  <= 1'b1; // [RULE19]
        end else if (rd && paddr == (c == 0 ? `OFF_CAPTURE1 : `OFF_CAPTURE2)) begin
          capture_flag[c]  <= 1'b0; // [RULE19]
        end
      end
    end
  end
  assign capture_irq = capture_flag & capture_irq_enable; // [RULE18]

  // Read mux
  always_comb begin
    unique case (paddr)
      `OFF_DUTY0:      rbyte = duty_cycle[0];
      `OFF_DUTY1:      rbyte = duty_cycle[1];
      `OFF_DUTY2:      rbyte = duty_cycle[2];
      `OFF_DUTY3:      rbyte = duty_cycle[3];
      `OFF_PWM_CTRL:   rbyte = {output_enable, polarity_bits};
      `OFF_TIMER_CS:   rbyte = {external_clock_select, prescale_select, counter_run,
                                1'b0, overflow_irq_enable, overflow_flag}; // [RULE4]
      `OFF_COUNTER:    rbyte = counter; // [RULE9]
      `OFF_RELOAD:     rbyte = reload_value;
      `OFF_CAPTURE_CS: rbyte = {2'b00, capture_edge, capture_irq_enable, capture_flag}; // [RULE16]
      `OFF_CAPTURE1:   rbyte = capture_value[0];
      `OFF_CAPTURE2:   rbyte = capture_value[1];
      default:         rbyte = 8'h00;
    endcase
  end
  assign prdata = {24'h000000, rbyte};

  chk_ovf_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    overflow |=> overflow_flag) else $error("overflow did not set flag"); // [RULE7]
  chk_ovf_reload: assert property (@(posedge pclk) disable iff (!presetn)
    overflow && !wr |=> counter == $past(reload_value)) else $error("no reload on overflow"); // [RULE10]
  chk_ovf_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    overflow_irq == (overflow_flag && overflow_irq_enable)) else $error("overflow irq gate"); // [RULE6]
  chk_frozen_count: assert property (@(posedge pclk) disable iff (!presetn)
    !counter_run && !wr |=> $stable(counter) && $stable(prescaler)) else $error("counter moved while stopped"); // [RULE3]
  chk_force_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    paddr == `OFF_TIMER_CS |-> prdata[`BIT_FORCE] == 1'b0) else $error("force bit read nonzero"); // [RULE4]
  chk_counter_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `OFF_COUNTER |=> counter == $past(pwdata[7:0]) && prescaler == 7'h00)
    else $error("counter write failed"); // [RULE24]
  chk_capture_hold: assert property (@(posedge pclk) disable iff (!presetn)
    capture_flag[0] && !(rd && paddr == `OFF_CAPTURE1) |=> $stable(capture_value[0]) && capture_flag[0])
    else $error("capture overwritten"); // [RULE23]
  chk_capture_irq: assert property (@(posedge pclk) disable iff (!presetn)
    capture_irq == (capture_flag & capture_irq_enable)) else $error("capture irq gate"); // [RULE18]
  chk_shadow_load: assert property (@(posedge pclk) disable iff (!presetn)
    overflow |=> compare_shadow[0] == $past(duty_cycle[0])) else $error("shadow not loaded"); // [RULE21]

  chk_shadow_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE21]
    !overflow |=> $stable(compare_shadow[0]))
    else $error("shadow changed between overflows");

  chk_force_loads: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    wr && paddr == `OFF_TIMER_CS && pwdata[`BIT_FORCE]
    |=> counter == $past(reload_value) && prescaler == 7'h00)
    else $error("force reload failed");

  chk_ovf_read_clears: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
    rd && paddr == `OFF_TIMER_CS && !overflow |=> !overflow_flag)
    else $error("overflow flag not cleared by read");

  chk_ovf_no_write_set: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
    wr && !overflow && !overflow_flag |=> !overflow_flag)
    else $error("write set overflow flag");

  chk_count_step: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
    count_tick && !overflow && !wr |=> counter == $past(counter) + 8'h01)
    else $error("counter did not step");

  chk_ext_gate: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    external_clock_select && !(ext_clock && !ext_prev) |-> !count_tick)
    else $error("tick without external edge");

  chk_prescale_tap: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    prescale_select == 3'h7 && count_tick |-> prescaler == 7'h7F)
    else $error("divide by 128 tap wrong");

  chk_reset_zero: assert property (@(posedge pclk) // [RULE20]
    !presetn |-> !external_clock_select && prescale_select == 3'h0 && !counter_run
                 && !overflow_irq_enable && !overflow_flag)
    else $error("control register not zero in reset");

  chk_oe_follows: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
    1'b1 |=> waveform_oe == $past(output_enable))
    else $error("output enable mismatch");

  chk_wave_level: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
    1'b1 |=> waveform_out[0] == ($past(output_enable[0])
                                 && (($past(counter) <= $past(compare_shadow[0])) ^ $past(polarity_bits[0]))))
    else $error("waveform level wrong");

  chk_cs_reserved: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
    paddr == `OFF_CAPTURE_CS |-> prdata[7:6] == 2'b00)
    else $error("reserved capture bits nonzero");

  chk_capture_copy: assert property (@(posedge pclk) disable iff (!presetn) // [RULE22]
    cap_event[1] && !capture_flag[1] |=> capture_value[1] == $past(counter) && capture_flag[1])
    else $error("capture did not copy counter");

  chk_capture_hold2: assert property (@(posedge pclk) disable iff (!presetn) // [RULE23]
    capture_flag[1] && !(rd && paddr == `OFF_CAPTURE2) |=> $stable(capture_value[1]) && capture_flag[1])
    else $error("second capture overwritten");

  chk_capture_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RULE19]
    rd && paddr == `OFF_CAPTURE1 && capture_flag[0] |=> !capture_flag[0])
    else $error("capture flag not cleared by read");

  chk_bus_response: assert property (@(posedge pclk) disable iff (!presetn) // [RULE25]
    pready && !pslverr && prdata[31:8] == 24'h000000)
    else $error("bus response wrong");
endmodule
`default_nettype wire
